// ===== shared/mdrr_regs.svh
`ifndef MDRR_REGS_SVH
`define MDRR_REGS_SVH
// register offsets are byte addresses of aligned words
`define MDRR_OFS_MIX 8'h40
`define MDRR_OFS_DIF 8'h44
`define MDRR_OFS_SEL 8'h48
`define MDRR_OFS_LVL 8'h4C
// printed register indices
`define MDRR_IDX_MIX 8'h10
`define MDRR_IDX_DIF 8'h11
`define MDRR_IDX_SEL 8'h12
`define MDRR_IDX_LVL 8'h13
// writable masks
`define MDRR_MASK_MIX 8'h3F
`define MDRR_MASK_DIF 8'h07
`define MDRR_MASK_SEL 8'hFF
`define MDRR_MASK_LVL 8'h7F
// reset values
`define MDRR_RST_MIX 8'h00
`define MDRR_RST_DIF 8'h00
`define MDRR_RST_SEL 8'h00
`define MDRR_RST_LVL 8'h10
// field positions
`define MDRR_DIF_EN 0
`define MDRR_DIF_HP 1
`define MDRR_DIF_MO 2
`define MDRR_LVL_MUTE 4
`define MDRR_LVL_GAIN 5
`define MDRR_LVL_PWR 6
`define MDRR_ATT_MSB 3
// mixing enable positions
`define MDRR_MIX_P1_HP 0
`define MDRR_MIX_P1_LO 1
`define MDRR_MIX_P2_HP 2
`define MDRR_MIX_P2_LO 3
`define MDRR_MIX_P3_HP 4
`define MDRR_MIX_P3_LO 5
// mono source positions
`define MDRR_SEL_DACL 0
`define MDRR_SEL_DACR 1
`define MDRR_SEL_LIN_LSB 2
`define MDRR_SEL_LIN_MSB 7
// supported widths
`define MDRR_REG_WIDTH 8
`define MDRR_ATT_WIDTH 4
`endif

// ===== shared/mdrr_pkg.sv
package mdrr_pkg;
   typedef logic [7:0] mdrr_byte_type;
   typedef logic [3:0] mdrr_att_type;
endpackage : mdrr_pkg

// ===== design/mdrr_top.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "mdrr_regs.svh"
module mdrr_top
   import mdrr_pkg::*;
#(
   parameter int REG_WIDTH = `MDRR_REG_WIDTH,
   parameter int ATT_WIDTH = `MDRR_ATT_WIDTH
)
(
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // lineout mixing
   output logic [2:0] pair_avg_to_lineout_o,
   output logic diff_to_lineout_o,
   // headphone mixing
   output logic [2:0] pair_avg_to_headphone_o,
   output logic diff_pair_to_headphone_o,
   // input pin mode
   output logic first_inputs_differential_o,
   // mono mixing
   output logic dac_left_to_mono_o,
   output logic dac_right_to_mono_o,
   output logic [5:0] line_inputs_to_mono_o,
   output logic diff_pair_to_mono_o,
   // mono level and power
   output logic [3:0] mono_attenuation_level_o,
   output logic mono_silence_o,
   output logic dac_to_mono_gain_o,
   output logic mono_amp_power_o,
   output logic mono_output_pin_oe_n_o
);
   mdrr_byte_type mix_reg;
   mdrr_byte_type dif_reg;
   mdrr_byte_type sel_reg;
   mdrr_byte_type lvl_reg;
   logic ack_reg;
   logic err_reg;
   logic [31:0] rdat_reg;
   logic req;
   logic hit;
   logic wr;
   mdrr_byte_type rd_next;
   logic wr_mix;
   logic wr_dif;
   logic wr_sel;
   logic wr_lvl;
   mdrr_att_type att_field;
   logic mute_field;
   logic [5:0] line_field;
   logic [2:0] pair_lo_field;
   logic [2:0] pair_hp_field;

   // the field map is fixed, so any other width would misplace every routing bit
   if (REG_WIDTH != `MDRR_REG_WIDTH || ATT_WIDTH != `MDRR_ATT_WIDTH) begin : g_width_chk
      $error("mdrr_top supports only the documented register and attenuation widths");
   end

   assign req = cyc_i && stb_i && !ack_reg && !err_reg;
   assign hit = (adr_i == `MDRR_OFS_MIX) || (adr_i == `MDRR_OFS_DIF) ||
                (adr_i == `MDRR_OFS_SEL) || (adr_i == `MDRR_OFS_LVL);
   assign wr = req && hit && we_i && sel_i[0];
   assign wr_mix = wr && (adr_i == `MDRR_OFS_MIX);
   assign wr_dif = wr && (adr_i == `MDRR_OFS_DIF);
   assign wr_sel = wr && (adr_i == `MDRR_OFS_SEL);
   assign wr_lvl = wr && (adr_i == `MDRR_OFS_LVL);

   assign pair_lo_field = {mix_reg[`MDRR_MIX_P3_LO], mix_reg[`MDRR_MIX_P2_LO],
                           mix_reg[`MDRR_MIX_P1_LO]};
   assign pair_hp_field = {mix_reg[`MDRR_MIX_P3_HP], mix_reg[`MDRR_MIX_P2_HP],
                           mix_reg[`MDRR_MIX_P1_HP]};
   assign line_field = sel_reg[`MDRR_SEL_LIN_MSB:`MDRR_SEL_LIN_LSB];
   assign att_field = lvl_reg[`MDRR_ATT_MSB:0];
   assign mute_field = lvl_reg[`MDRR_LVL_MUTE];

   // one wait state: answer comes one edge after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req && hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_reg <= 1'b0;
      end else begin
         err_reg <= req && !hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mix_reg <= `MDRR_RST_MIX;
      end else if (wr_mix) begin
         mix_reg <= dat_i[7:0] & `MDRR_MASK_MIX;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dif_reg <= `MDRR_RST_DIF;
      end else if (wr_dif) begin
         dif_reg <= dat_i[7:0] & `MDRR_MASK_DIF;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_reg <= `MDRR_RST_SEL;
      end else if (wr_sel) begin
         sel_reg <= dat_i[7:0] & `MDRR_MASK_SEL;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_reg <= `MDRR_RST_LVL;
      end else if (wr_lvl) begin
         lvl_reg <= dat_i[7:0] & `MDRR_MASK_LVL;
      end
   end

   always_comb begin
      rd_next = 8'h00;
      case (adr_i)
         `MDRR_OFS_MIX: rd_next = mix_reg;
         `MDRR_OFS_DIF: rd_next = dif_reg;
         `MDRR_OFS_SEL: rd_next = sel_reg;
         `MDRR_OFS_LVL: rd_next = lvl_reg;
         default: rd_next = 8'h00;
      endcase
   end

   // read data captured with the ack so it stands stable for the master
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_reg <= 32'h0000_0000;
      end else if (req) begin
         rdat_reg <= {24'h00_0000, rd_next};
      end
   end

   assign ack_o = ack_reg;
   assign err_o = err_reg;
   assign dat_o = rdat_reg;

   // routing outputs follow the registers directly; the analog side settles on its own
   assign pair_avg_to_lineout_o = pair_lo_field;
   assign pair_avg_to_headphone_o = pair_hp_field;
   assign diff_to_lineout_o = dif_reg[`MDRR_DIF_EN];
   assign first_inputs_differential_o = dif_reg[`MDRR_DIF_EN];
   // the stored bit reads back as written, only its effect is gated
   assign diff_pair_to_headphone_o = dif_reg[`MDRR_DIF_EN] && dif_reg[`MDRR_DIF_HP];
   assign diff_pair_to_mono_o = dif_reg[`MDRR_DIF_EN] && dif_reg[`MDRR_DIF_MO];
   assign dac_left_to_mono_o = sel_reg[`MDRR_SEL_DACL];
   assign dac_right_to_mono_o = sel_reg[`MDRR_SEL_DACR];
   assign line_inputs_to_mono_o = line_field;
   assign mono_silence_o = mute_field;
   // mono mute taken as the governing bit, not the headphone one
   assign mono_attenuation_level_o = mute_field ? 4'h0 : att_field;
   assign dac_to_mono_gain_o = lvl_reg[`MDRR_LVL_GAIN];
   assign mono_amp_power_o = lvl_reg[`MDRR_LVL_PWR];
   assign mono_output_pin_oe_n_o = !lvl_reg[`MDRR_LVL_PWR];

   // assertions: bus handshake
   ack_one_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && hit)
      |=> ack_o ##1 !ack_o)
      else $error("ack not one cycle after request");
   err_unmap_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !hit)
      |=> (err_o && !ack_o))
      else $error("unmapped access not refused");
   ack_err_excl_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ack_o
      |-> !err_o)
      else $error("ack and error together");
   ack_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ack_o
      |=> !ack_o)
      else $error("ack longer than one cycle");
   err_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      err_o
      |=> !err_o)
      else $error("error longer than one cycle");
   read_mix_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == `MDRR_OFS_MIX)
      |=> dat_o[7:0] == $past(mix_reg))
      else $error("mixing register read wrong");

   // reserved bits and refused writes
   resv_zero_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ack_o
      |-> dat_o[31:8] == 24'h00_0000 && !(($past(adr_i) == `MDRR_OFS_LVL) && dat_o[7]))
      else $error("reserved bits read nonzero");
   resv_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (mix_reg & ~`MDRR_MASK_MIX) == 8'h00 && (dif_reg & ~`MDRR_MASK_DIF) == 8'h00
      && (lvl_reg & ~`MDRR_MASK_LVL) == 8'h00)
      else $error("reserved bits stored");
   unmap_keep_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !hit)
      |=> $stable(mix_reg) && $stable(dif_reg) && $stable(sel_reg) && $stable(lvl_reg))
      else $error("unmapped write landed");
   lane_off_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && we_i && !sel_i[0])
      |=> $stable(mix_reg) && $stable(dif_reg) && $stable(sel_reg) && $stable(lvl_reg))
      else $error("write with low lane off landed");
   reg_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !wr
      |=> $stable(mix_reg) && $stable(dif_reg) && $stable(sel_reg) && $stable(lvl_reg))
      else $error("register changed without a write");

   // mixing enables
   mix_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_mix
      |=> pair_avg_to_lineout_o == {$past(dat_i[5]), $past(dat_i[3]), $past(dat_i[1])})
      else $error("lineout average enables wrong");
   hp_avg_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_mix
      |=> pair_avg_to_headphone_o == {$past(dat_i[4]), $past(dat_i[2]), $past(dat_i[0])})
      else $error("headphone average enables wrong");

   // differential pair
   dif_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_dif
      |=> diff_to_lineout_o == $past(dat_i[`MDRR_DIF_EN]))
      else $error("differential enable not stored");
   diff_gate_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !diff_to_lineout_o
      |-> !diff_pair_to_headphone_o && !diff_pair_to_mono_o)
      else $error("diff route active while disabled");
   diff_hp_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_dif && dat_i[`MDRR_DIF_EN])
      |=> diff_pair_to_headphone_o == $past(dat_i[`MDRR_DIF_HP]))
      else $error("diff to headphone not applied");
   diff_mo_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_dif && dat_i[`MDRR_DIF_EN])
      |=> diff_pair_to_mono_o == $past(dat_i[`MDRR_DIF_MO]))
      else $error("diff to mono not applied");
   diff_pins_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1
      |-> first_inputs_differential_o == diff_to_lineout_o)
      else $error("input pin mode mismatched");

   // mono sources and level
   mono_sel_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_sel
      |=> {line_inputs_to_mono_o, dac_right_to_mono_o, dac_left_to_mono_o} == $past(dat_i[7:0]))
      else $error("mono source select wrong");
   att_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_lvl && !dat_i[`MDRR_LVL_MUTE])
      |=> mono_attenuation_level_o == $past(dat_i[`MDRR_ATT_MSB:0]))
      else $error("attenuation not applied");
   att_unmuted_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !mono_silence_o
      |-> mono_attenuation_level_o == lvl_reg[`MDRR_ATT_MSB:0])
      else $error("attenuation lost while unmuted");
   mute_att_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      mono_silence_o
      |-> mono_attenuation_level_o == 4'h0)
      else $error("attenuation leaks through mute");
   mute_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_lvl
      |=> mono_silence_o == $past(dat_i[`MDRR_LVL_MUTE]))
      else $error("mono mute not stored");
   gain_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_lvl
      |=> dac_to_mono_gain_o == $past(dat_i[`MDRR_LVL_GAIN]))
      else $error("mono gain not stored");
   pwr_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_lvl
      |=> mono_amp_power_o == $past(dat_i[`MDRR_LVL_PWR]))
      else $error("mono power not stored");
   pwr_hiz_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1
      |-> mono_output_pin_oe_n_o != mono_amp_power_o)
      else $error("mono pin enable wrong");

   // state right after reset release; before the first reset edge the registers are unknown
   mute_rst_a: assert property (
      @(posedge clk_i)
      ($past(rst_i) && !rst_i)
      |-> mono_silence_o && !mono_amp_power_o && !dac_to_mono_gain_o)
      else $error("mono level reset wrong");
   route_rst_a: assert property (
      @(posedge clk_i)
      ($past(rst_i) && !rst_i)
      |-> pair_avg_to_lineout_o == 3'h0 && !diff_to_lineout_o && !dac_left_to_mono_o
         && line_inputs_to_mono_o == 6'h00 && mono_attenuation_level_o == 4'h0)
      else $error("routing reset wrong");

   write_c: cover property (@(posedge clk_i) disable iff (rst_i) wr ##1 ack_o);
   read_c: cover property (@(posedge clk_i) disable iff (rst_i) (req && hit && !we_i) ##1 ack_o);
   diff_c: cover property (@(posedge clk_i) disable iff (rst_i) diff_pair_to_mono_o);
   unmute_c: cover property (@(posedge clk_i) disable iff (rst_i)
      !mono_silence_o && mono_amp_power_o && mono_attenuation_level_o != 4'h0);
   err_c: cover property (@(posedge clk_i) disable iff (rst_i) err_o);
endmodule : mdrr_top

// ===== verif/mdrr_top_tb.sv
`timescale 1ns/1ps
`include "mdrr_regs.svh"
module mdrr_top_tb
   import mdrr_pkg::*;
   ;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, err_o, difflo, diffhp, firstdiff, dacl, dacr, diffmo, mute, gain, pwr, oen;
   logic [2:0] lo, hp;
   logic [5:0] lin;
   logic [3:0] att;
   mdrr_byte_type sh [4];
   int fail_count = 0, tests_run = 0;
   // all routing outputs packed so one compare covers every field
   wire logic [31:0] outs = {6'h00, lo, difflo, hp, diffhp, firstdiff, dacl, dacr, lin, diffmo,
      att, mute, gain, pwr, oen};
   always #2.5 clk_i = ~clk_i;
   mdrr_top u_mdrr_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .err_o(err_o), .pair_avg_to_lineout_o(lo), .diff_to_lineout_o(difflo),
      .pair_avg_to_headphone_o(hp), .diff_pair_to_headphone_o(diffhp),
      .first_inputs_differential_o(firstdiff), .dac_left_to_mono_o(dacl),
      .dac_right_to_mono_o(dacr), .line_inputs_to_mono_o(lin), .diff_pair_to_mono_o(diffmo),
      .mono_attenuation_level_o(att), .mono_silence_o(mute), .dac_to_mono_gain_o(gain),
      .mono_amp_power_o(pwr), .mono_output_pin_oe_n_o(oen));
   // expected routing from the four register bytes
   function automatic logic [31:0] model(mdrr_byte_type m, d, s, l);
      return {6'h00, m[5], m[3], m[1], d[0], m[4], m[2], m[0], d[0] & d[1], d[0], s[0], s[1],
         s[7:2], d[0] & d[2], l[4] ? 4'h0 : l[3:0], l[4], l[5], l[6], !l[6]};
   endfunction : model
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
      q = dat_o;
      e = err_o;
      if (n >= 50) chk("answer", 32'h1, 32'h0);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic put(input logic [7:0] a, input mdrr_byte_type v, input mdrr_byte_type k);
      logic [31:0] q;
      logic e;
      wb(1'b1, a, {24'h0, v}, 4'hF, q, e);
      wb(1'b0, a, 32'h0, 4'hF, q, e);
      chk("readback", {24'h0, v & k}, q);
      sh[a[3:2]] = v & k;
      chk("outputs", model(sh[0], sh[1], sh[2], sh[3]), outs);
   endtask : put
   initial begin
      logic [31:0] q;
      logic e;
      sh = '{`MDRR_RST_MIX, `MDRR_RST_DIF, `MDRR_RST_SEL, `MDRR_RST_LVL};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, `MDRR_OFS_MIX + 8'(i * 4), 32'h0, 4'hF, q, e);
         chk("reset value", {24'h0, sh[i]}, q);
      end
      chk("reset outputs", 32'h0000_0009, outs);
      $display("done: reset");
      put(`MDRR_OFS_MIX, 8'hFF, `MDRR_MASK_MIX);
      put(`MDRR_OFS_MIX, 8'h2A, `MDRR_MASK_MIX);
      put(`MDRR_OFS_MIX, 8'h15, `MDRR_MASK_MIX);
      $display("done: mixing");
      put(`MDRR_OFS_DIF, 8'h06, `MDRR_MASK_DIF);
      put(`MDRR_OFS_DIF, 8'h03, `MDRR_MASK_DIF);
      put(`MDRR_OFS_DIF, 8'hFD, `MDRR_MASK_DIF);
      put(`MDRR_OFS_DIF, 8'h00, `MDRR_MASK_DIF);
      $display("done: differential");
      for (int i = 0; i < 8; i++) put(`MDRR_OFS_SEL, 8'(1 << i), `MDRR_MASK_SEL);
      $display("done: mono sources");
      put(`MDRR_OFS_LVL, 8'h1F, `MDRR_MASK_LVL);
      put(`MDRR_OFS_LVL, 8'h6A, `MDRR_MASK_LVL);
      put(`MDRR_OFS_LVL, 8'hFF, `MDRR_MASK_LVL);
      put(`MDRR_OFS_LVL, 8'h05, `MDRR_MASK_LVL);
      $display("done: mono level");
      // an unmapped write must not land anywhere, nor a write with the low lane off
      wb(1'b1, 8'h50, 32'hFF, 4'hF, q, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      wb(1'b1, `MDRR_OFS_LVL, 32'h7F, 4'hE, q, e);
      wb(1'b0, `MDRR_OFS_LVL, 32'h0, 4'hF, q, e);
      chk("lane off", {24'h0, sh[3]}, q);
      chk("outputs", model(sh[0], sh[1], sh[2], sh[3]), outs);
      $display("done: refusals");
      print_verdict();
   end
   initial begin
      #10000;
      fail_count++;
      print_verdict();
   end
endmodule : mdrr_top_tb
